/* logic/lircl_pkg.sv */
// constants shared by the input-range configuration loader files
// assumes a 200 MHz system clock and 32-bit AHB-Lite register access
package lircl_pkg;
	localparam int CFG_W = 6;
	localparam int RANGE_W = 3;
	localparam logic [5:0] CFG_RESET = 6'h3f;
	localparam logic [5:0] CFG_ZERO = 6'h00;
	localparam int CH1_LSB = 3;
	localparam int CH0_LSB = 0;
	localparam int EDGE_CNT_W = 3;
	localparam logic [2:0] WORD_LAST_EDGE = 3'h5;
	localparam int RESULT_W = 18;
	localparam int PACKET_W = 24;
	localparam int PAIR_W = 48;
	localparam logic [1:0] PKT_PAD = 2'h0;
	localparam logic PKT_ID_CH0 = 1'h0;
	localparam logic PKT_ID_CH1 = 1'h1;
	localparam int POWERUP_WAIT_MS = 10;
	localparam int CLK_KHZ = 200000;
	localparam int POWERUP_WAIT_CYCLES = POWERUP_WAIT_MS * CLK_KHZ;
	localparam logic [2:0] LINK_SYNC_RESET = 3'h4;
	localparam logic [7:0] ADDR_CONFIG = 8'h00;
	localparam logic [7:0] ADDR_CTRL = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic CTRL_LINK_EN_RESET = 1'h1;
	localparam int STAT_WIN_BIT = 0;
	localparam int STAT_CS_BIT = 1;
	localparam int STAT_EDGE_LSB = 8;
	localparam int STAT_APPLIED_LSB = 16;
	localparam int STAT_ZERO_LSB = 24;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	typedef enum logic [1:0] {
		LIRCL_WIN_POWERUP = 2'h0,
		LIRCL_WIN_OPEN = 2'h1,
		LIRCL_WIN_CLOSED = 2'h3
	} lircl_win_t;
endpackage

/* logic/lircl_sync.sv */
// two-flop synchroniser for pins arriving from outside the system clock
// assumes each bit is a slow level compared with sys_clk_i
`timescale 1ns/1ps
module lircl_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta;

	// first stage feeds only the second stage
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			meta <= RESET_VAL;
			sync_o <= RESET_VAL;
		end else begin
			meta <= async_i;
			sync_o <= meta;
		end
	end
endmodule

/* logic/lircl_word_rx.sv */
// assembles 6-bit configuration words from double-edge serial bits
// assumes edge_i is a one-cycle pulse per serial clock edge, bit_i aligned with it
`timescale 1ns/1ps
module lircl_word_rx (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic clear_i,
	input wire logic edge_i,
	input wire logic bit_i,
	output logic [5:0] word_o,
	output logic word_valid_o,
	output logic [2:0] edge_count_o
);
	logic [4:0] partial;

	always_ff @(posedge sys_clk_i) begin
		if (reset_i || clear_i) begin
			edge_count_o <= '0;
			partial <= '0;
		end else if (edge_i) begin
			partial <= {partial[3:0], bit_i};
			if (edge_count_o == lircl_pkg::WORD_LAST_EDGE) begin
				edge_count_o <= '0;
			end else begin
				edge_count_o <= edge_count_o + 3'h1;
			end
		end
	end

	// sixth edge (third falling) completes a word; leftover bits are kept until clear_i
	always_ff @(posedge sys_clk_i) begin
		if (reset_i || clear_i) begin
			word_valid_o <= 1'b0;
			word_o <= '0;
		end else begin
			word_valid_o <= edge_i && (edge_count_o == lircl_pkg::WORD_LAST_EDGE);
			if (edge_i && (edge_count_o == lircl_pkg::WORD_LAST_EDGE)) begin
				word_o <= {partial, bit_i};
			end
		end
	end

	word_done_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		edge_i && !clear_i && edge_count_o == 3'h5 |=> word_valid_o && edge_count_o == 3'h0)
		else $error("sixth edge did not complete a word");
	no_early_word_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		!(edge_i && edge_count_o == 3'h5) |=> !word_valid_o)
		else $error("word emitted without six edges");
	clear_align_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		clear_i |=> edge_count_o == 3'h0 && !word_valid_o)
		else $error("window opening did not realign words");
endmodule

/* logic/lircl_top.sv */
// input-range configuration loader with serial result packets and AHB-Lite registers
// assumes busy_i and conv_start_i come from the converter core on sys_clk_i;
// link pins are asynchronous and pass the two-flop synchroniser first
//
// Overview of operation
// - reset loads all ones, range seven both.
// - host shifts new six-bit word during window.
// - words accepted only inside an open window.
// - new range applies to the very next conversion.
// - code zero disables channel, shortening conversion.
// - re-enabled channel needs no extra settling.
// - fewer than six edges discard partial word; the code keeps it until the next window opening.
// - six edges load received nonzero word.
// - all-zero word leaves register untouched.
// - each complete word applies in order.
// - third falling edge completes first word.
// - bits sampled on both serial clock edges.
// - window opens after power-up wait, busy fall.
// - bus active only with chip select low.
// - 24-bit packets, alternating channels, MSB first.
//
// Added by the designer: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
module lircl_top #(
	parameter int POWERUP_WAIT_CYCLES = lircl_pkg::POWERUP_WAIT_CYCLES
) (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic serial_clock_in_i,
	input wire logic serial_config_in_i,
	input wire logic chip_select_n_i,
	output logic serial_result_out_o,
	output logic serial_result_oe_o,
	output logic serial_clock_echo_o,
	output logic serial_clock_echo_oe_o,
	input wire logic busy_i,
	input wire logic conv_start_i,
	input wire logic [17:0] result_ch0_i,
	input wire logic [17:0] result_ch1_i,
	output logic [2:0] range_ch0_o,
	output logic [2:0] range_ch1_o,
	output logic [1:0] chan_enable_o,
	output logic window_open_o
);
	function automatic logic reg_hit(input logic [31:0] addr, input logic [7:0] offset);
		reg_hit = (addr[31:8] == 24'h000000) && (addr[7:0] == offset);
	endfunction

	function automatic logic [23:0] make_packet(input logic [17:0] result, input logic id, input logic [2:0] code);
		make_packet = {result, lircl_pkg::PKT_PAD, id, code};
	endfunction

	logic [5:0] cfg;
	logic [5:0] next_cfg;
	logic [5:0] conv_cfg;
	logic ctrl_link_en;
	lircl_pkg::lircl_win_t win_state;
	logic [31:0] pwr_cnt;
	logic pwr_done;
	logic busy_prev;
	logic busy_fall;
	logic open_evt;
	logic cs_n_s;
	logic sclk_s;
	logic sdata_s;
	logic sclk_prev;
	logic link_edge;
	logic link_active;
	logic accept_edge;
	logic [5:0] rx_word;
	logic rx_valid;
	logic [2:0] rx_edges;
	logic load_cfg;
	logic [47:0] pkt_sh;
	logic [7:0] words_applied;
	logic [7:0] words_zero;
	logic a_valid;
	logic a_write;
	logic [31:0] a_addr;
	logic [31:0] status_word;

	lircl_sync #(
		.WIDTH(3),
		.RESET_VAL(lircl_pkg::LINK_SYNC_RESET)
	) u_sync (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.async_i({chip_select_n_i, serial_clock_in_i, serial_config_in_i}),
		.sync_o({cs_n_s, sclk_s, sdata_s})
	);

	// both serial clock edges count, one pulse per edge
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			sclk_prev <= 1'b0;
		end else begin
			sclk_prev <= sclk_s;
		end
	end

	assign link_edge = sclk_s ^ sclk_prev;
	assign link_active = !cs_n_s && ctrl_link_en;
	assign accept_edge = link_edge && link_active && (win_state == lircl_pkg::LIRCL_WIN_OPEN);

	lircl_word_rx u_word_rx (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.clear_i(open_evt),
		.edge_i(accept_edge),
		.bit_i(sdata_s),
		.word_o(rx_word),
		.word_valid_o(rx_valid),
		.edge_count_o(rx_edges)
	);

	// power-up wait, then windows track busy falling and conversion start
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			pwr_cnt <= '0;
		end else if (!pwr_done) begin
			pwr_cnt <= pwr_cnt + 32'h1;
		end
	end

	assign pwr_done = (pwr_cnt == 32'(POWERUP_WAIT_CYCLES - 1));

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			busy_prev <= 1'b0;
		end else begin
			busy_prev <= busy_i;
		end
	end

	assign busy_fall = busy_prev && !busy_i;
	assign open_evt = (win_state == lircl_pkg::LIRCL_WIN_POWERUP) ? pwr_done : busy_fall;

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			win_state <= lircl_pkg::LIRCL_WIN_POWERUP;
		end else begin
			case (win_state)
				lircl_pkg::LIRCL_WIN_POWERUP: begin
					if (pwr_done) begin
						win_state <= lircl_pkg::LIRCL_WIN_OPEN;
					end
				end
				lircl_pkg::LIRCL_WIN_OPEN: begin
					// a busy fall in the same cycle reopens; opening wins
					if (conv_start_i && !busy_fall) begin
						win_state <= lircl_pkg::LIRCL_WIN_CLOSED;
					end
				end
				lircl_pkg::LIRCL_WIN_CLOSED: begin
					if (busy_fall) begin
						win_state <= lircl_pkg::LIRCL_WIN_OPEN;
					end
				end
				default: begin
					win_state <= lircl_pkg::LIRCL_WIN_POWERUP;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			window_open_o <= 1'b0;
		end else begin
			window_open_o <= (win_state == lircl_pkg::LIRCL_WIN_OPEN);
		end
	end

	// the word is checked here, the window already gated its edges
	assign load_cfg = rx_valid && (rx_word != lircl_pkg::CFG_ZERO);

	always_comb begin
		next_cfg = cfg;
		if (load_cfg) begin
			next_cfg = rx_word;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			cfg <= lircl_pkg::CFG_RESET;
			chan_enable_o <= 2'h3;
		end else begin
			cfg <= next_cfg;
			// no settling hold-off either way; the core sees enables at once
			chan_enable_o[1] <= |next_cfg[5:3];
			chan_enable_o[0] <= |next_cfg[2:0];
		end
	end

	// ranges feed the core directly so the next conversion uses them
	assign range_ch1_o = cfg[lircl_pkg::CH1_LSB +: lircl_pkg::RANGE_W];
	assign range_ch0_o = cfg[lircl_pkg::CH0_LSB +: lircl_pkg::RANGE_W];

	// ranges in force for the conversion now running, reported in its packets
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			conv_cfg <= lircl_pkg::CFG_RESET;
		end else if (conv_start_i) begin
			conv_cfg <= cfg;
		end
	end

	// two packets in one ring; rotating keeps the channels alternating
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			pkt_sh <= '0;
		end else if (open_evt) begin
			pkt_sh <= {make_packet(result_ch0_i, lircl_pkg::PKT_ID_CH0, conv_cfg[2:0]),
				make_packet(result_ch1_i, lircl_pkg::PKT_ID_CH1, conv_cfg[5:3])};
		end else if (link_edge && link_active) begin
			pkt_sh <= {pkt_sh[46:0], pkt_sh[47]};
		end
	end

	// echo is delayed by the same two stages as the data it frames
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			serial_result_out_o <= 1'b0;
			serial_clock_echo_o <= 1'b0;
			serial_result_oe_o <= 1'b0;
			serial_clock_echo_oe_o <= 1'b0;
		end else begin
			serial_result_out_o <= pkt_sh[47];
			serial_clock_echo_o <= sclk_prev;
			serial_result_oe_o <= !cs_n_s;
			serial_clock_echo_oe_o <= !cs_n_s;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			words_applied <= '0;
			words_zero <= '0;
		end else if (rx_valid) begin
			if (load_cfg) begin
				words_applied <= words_applied + 8'h01;
			end else begin
				words_zero <= words_zero + 8'h01;
			end
		end
	end

	always_comb begin
		status_word = '0;
		status_word[lircl_pkg::STAT_WIN_BIT] = (win_state == lircl_pkg::LIRCL_WIN_OPEN);
		status_word[lircl_pkg::STAT_CS_BIT] = !cs_n_s;
		status_word[lircl_pkg::STAT_EDGE_LSB +: 3] = rx_edges;
		status_word[lircl_pkg::STAT_APPLIED_LSB +: 8] = words_applied;
		status_word[lircl_pkg::STAT_ZERO_LSB +: 8] = words_zero;
	end

	// zero-wait slave: read data prepared at the address phase edge
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			a_valid <= 1'b0;
			a_write <= 1'b0;
			a_addr <= '0;
			hrdata_o <= '0;
		end else if (hready_i) begin
			a_valid <= hsel_i && htrans_i[1];
			a_write <= hwrite_i;
			a_addr <= haddr_i;
			hrdata_o <= '0;
			if (hsel_i && htrans_i[1] && !hwrite_i) begin
				if (reg_hit(haddr_i, lircl_pkg::ADDR_CONFIG)) begin
					hrdata_o <= {26'h0, cfg};
				end else if (reg_hit(haddr_i, lircl_pkg::ADDR_CTRL)) begin
					hrdata_o <= {31'h0, ctrl_link_en};
				end else if (reg_hit(haddr_i, lircl_pkg::ADDR_STATUS)) begin
					hrdata_o <= status_word;
				end
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			ctrl_link_en <= lircl_pkg::CTRL_LINK_EN_RESET;
		end else if (a_valid && a_write && reg_hit(a_addr, lircl_pkg::ADDR_CTRL)) begin
			ctrl_link_en <= hwdata_i[0];
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end else begin
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end
	end

	reset_default_a: assert property (@(posedge sys_clk_i)
		$fell(reset_i) |-> cfg == 6'h3f && chan_enable_o == 2'h3)
		else $error("configuration not all ones after reset");
	outside_ignored_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		cfg != $past(cfg) |-> $past(rx_valid) && $past(rx_word) == cfg)
		else $error("configuration changed without a received word");
	// checks the edge counter itself, not the gate expression that feeds it
	window_gate_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(win_state != lircl_pkg::LIRCL_WIN_OPEN || cs_n_s || !ctrl_link_en) && !open_evt
			|=> $stable(rx_edges) && !rx_valid)
		else $error("edge accepted outside open window");
	word_load_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		rx_valid && rx_word != 6'h00 |=> cfg == $past(rx_word))
		else $error("nonzero word not loaded");
	zero_word_hold_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		rx_valid && rx_word == 6'h00 |=> $stable(cfg) ##1 $stable(words_applied))
		else $error("zero word modified configuration");
	chan_disable_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		chan_enable_o == {range_ch1_o != 3'h0, range_ch0_o != 3'h0})
		else $error("channel enables disagree with range codes");
	window_open_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		busy_fall && win_state != lircl_pkg::LIRCL_WIN_POWERUP |=> win_state == lircl_pkg::LIRCL_WIN_OPEN ##1 window_open_o)
		else $error("busy fall did not open a window");
	cs_tristate_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		cs_n_s |=> !serial_result_oe_o && !serial_clock_echo_oe_o)
		else $error("serial outputs driven with chip select high");
	packet_load_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		open_evt |=> pkt_sh[47:24] == {$past(result_ch0_i), 2'h0, 1'h0, $past(conv_cfg[2:0])}
			&& pkt_sh[23:0] == {$past(result_ch1_i), 2'h0, 1'h1, $past(conv_cfg[5:3])})
		else $error("result packets loaded wrongly");
endmodule

/* tb/lircl_host_model.sv */
// host-side model of the serial link: DDR config frames, result capture
// assumes the device samples both clock edges through a two-flop sync
`timescale 1ns/1ps
module lircl_host_model (
	output logic serial_clock_in_o,
	output logic serial_config_in_o,
	output logic chip_select_n_o,
	input wire logic serial_result_out_i,
	input wire logic serial_result_oe_i
);
	logic [31:0] rx_bits;
	initial begin
		serial_clock_in_o = 1'b0;
		serial_config_in_o = 1'b0;
		chip_select_n_o = 1'b1;
		rx_bits = '0;
	end
	// n must be even so the clock idles low again
	task automatic frame(input int n, input logic [31:0] bits, input logic sel);
		rx_bits = '0;
		#1.3;
		chip_select_n_o = ~sel;
		#40;
		for (int k = 0; k < n; k++) begin
			// data moves mid-phase, so it is stable around each edge
			serial_config_in_o = bits[n-1-k];
			#20;
			rx_bits = {rx_bits[30:0], serial_result_oe_i & serial_result_out_i};
			serial_clock_in_o = ~serial_clock_in_o;
			#20;
		end
		serial_config_in_o = 1'b0;
		#40;
		chip_select_n_o = 1'b1;
		#40;
	endtask
endmodule

/* tb/lvds_input_range_config_loader_tb_top.sv */
// self-checking bench for the range configuration loader
// assumes a 200 MHz clock and the host model on the serial link
`timescale 1ns/1ps
module lvds_input_range_config_loader_tb_top;
	logic sys_clk_i, reset_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
	logic [31:0] haddr_i, hwdata_i, hrdata_o, rd, v;
	logic [1:0] htrans_i, chan_enable_o;
	logic busy_i, conv_start_i, window_open_o, sck, serial_config_in, csn, serial_result_out, sdo_oe, sck_echo, sck_echo_oe;
	logic [17:0] result_ch0_i, result_ch1_i, res0;
	logic [2:0] range_ch0_o, range_ch1_o;
	logic [5:0] m_cfg;
	logic [5:0] tbl [3] = '{6'h28, 6'h02, 6'h3f};
	int err_total, n_tests;
	int n_app, n_zero;
	always #2.5 sys_clk_i = ~sys_clk_i;
	lircl_top #(.POWERUP_WAIT_CYCLES(20)) DUT (
		.sys_clk_i(sys_clk_i), .reset_i(reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
		.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
		.hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
		.serial_clock_in_i(sck), .serial_config_in_i(serial_config_in), .chip_select_n_i(csn),
		.serial_result_out_o(serial_result_out), .serial_result_oe_o(sdo_oe), .serial_clock_echo_o(sck_echo),
		.serial_clock_echo_oe_o(sck_echo_oe), .busy_i(busy_i), .conv_start_i(conv_start_i),
		.result_ch0_i(result_ch0_i), .result_ch1_i(result_ch1_i), .range_ch0_o(range_ch0_o),
		.range_ch1_o(range_ch1_o), .chan_enable_o(chan_enable_o), .window_open_o(window_open_o)
	);
	lircl_host_model host (
		.serial_clock_in_o(sck), .serial_config_in_o(serial_config_in), .chip_select_n_o(csn),
		.serial_result_out_i(serial_result_out), .serial_result_oe_i(sdo_oe)
	);
	task automatic final_report();
		if (err_total == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic hang();
		err_total++;
		$display("FAIL %0t wait expired", $time);
		final_report();
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_cfg();
		chk({24'h0, chan_enable_o, range_ch1_o, range_ch0_o}, {24'h0, |m_cfg[5:3], |m_cfg[2:0], m_cfg});
	endtask
	// window open, chip select idle, word counters from the model
	task automatic chk_status(input logic [2:0] e);
		ahb(1'b0, 32'h8, 32'h0);
		chk(rd, {8'(n_zero), 8'(n_app), 5'h0, e, 6'h0, 1'b0, 1'b1});
	endtask
	task automatic wait_rdy();
		int i;
		i = 0;
		do begin
			@(posedge sys_clk_i);
			i++;
		end while (hreadyout_o !== 1'b1 && i < 20);
		if (hreadyout_o !== 1'b1) hang();
	endtask
	task automatic wait_win();
		int i;
		for (i = 0; i < 60 && window_open_o !== 1'b1; i++) @(posedge sys_clk_i);
		if (window_open_o !== 1'b1) hang();
	endtask
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		hsel_i <= 1'b1;
		haddr_i <= a;
		htrans_i <= lircl_pkg::HTRANS_NONSEQ;
		hwrite_i <= wr;
		wait_rdy();
		hsel_i <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= d;
		wait_rdy();
		rd = hrdata_o;
	endtask
	task automatic start_conv();
		@(posedge sys_clk_i);
		conv_start_i <= 1'b1;
		busy_i <= 1'b1;
		@(posedge sys_clk_i);
		conv_start_i <= 1'b0;
	endtask
	task automatic end_conv();
		@(posedge sys_clk_i);
		res0 = 18'($urandom);
		result_ch0_i <= res0;
		result_ch1_i <= 18'($urandom);
		repeat (3) @(posedge sys_clk_i);
		busy_i <= 1'b0;
		wait_win();
	endtask
	// the model takes every whole word in order, zero words excepted
	task automatic xfer(input int n, input logic [31:0] bits, input logic sel, input logic en);
		logic [5:0] w;
		host.frame(n, bits, sel);
		for (int k = 0; en && k < n / 6; k++) begin
			w = 6'(bits >> (n - 6 * (k + 1)));
			if (w != 6'h00) begin
				m_cfg = w;
				n_app++;
			end else begin
				n_zero++;
			end
		end
		repeat (10) @(posedge sys_clk_i);
		chk_cfg();
		// chip select high again: link outputs released, echo idles low
		chk({28'h0, sck_echo, sck_echo_oe, sdo_oe, hresp_o}, 32'h0);
	endtask
	// differs from the current setting, so an ignored word is visible
	function automatic logic [31:0] rnd();
		logic [31:0] x;
		do x = 32'($urandom_range(63, 1)); while (x[5:0] == m_cfg);
		return x;
	endfunction
	initial begin
		repeat (100000) @(posedge sys_clk_i);
		hang();
	end
	initial begin
		sys_clk_i = 1'b0;
		reset_i = 1'b1;
		hsel_i = 1'b0;
		haddr_i = 32'h0;
		htrans_i = 2'h0;
		hwrite_i = 1'b0;
		hwdata_i = 32'h0;
		busy_i = 1'b0;
		conv_start_i = 1'b0;
		result_ch0_i = 18'h0;
		result_ch1_i = 18'h0;
		err_total = 0;
		n_tests = 0;
		n_app = 0;
		n_zero = 0;
		m_cfg = 6'h3f;
		void'($urandom(32'hd0d0b495));
		repeat (5) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		@(posedge sys_clk_i);
		chk_cfg();
		ahb(1'b0, 32'h0, 32'h0);
		chk(rd, 32'h3f);
		ahb(1'b0, 32'h4, 32'h0);
		chk(rd, 32'h1);
		ahb(1'b0, 32'h40, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, window_open_o}, 32'h0);
		wait_win();
		xfer(6, rnd(), 1'b1, 1'b1);
		ahb(1'b0, 32'h0, 32'h0);
		chk(rd, {26'h0, m_cfg});
		start_conv();
		xfer(6, rnd(), 1'b1, 1'b0);
		end_conv();
		xfer(4, 32'($urandom), 1'b1, 1'b0);
		chk_status(3'h4);
		start_conv();
		end_conv();
		xfer(6, rnd(), 1'b1, 1'b1);
		xfer(6, 32'h0, 1'b1, 1'b1);
		start_conv();
		end_conv();
		v = rnd();
		xfer(16, {16'h0, v[5:0], ~v[5:0], 4'h9}, 1'b1, 1'b1);
		chk(host.rx_bits, {16'h0, res0[17:2]});
		chk_status(3'h4);
		foreach (tbl[i]) begin
			start_conv();
			end_conv();
			xfer(6, {26'h0, tbl[i]}, 1'b1, 1'b1);
		end
		xfer(6, rnd(), 1'b0, 1'b0);
		// link disabled: edges are dropped until it is enabled again
		ahb(1'b1, 32'h4, 32'h0);
		xfer(6, rnd(), 1'b1, 1'b0);
		ahb(1'b1, 32'h4, 32'h1);
		final_report();
	end
endmodule
